// *** ecpp_pkg.sv ***
// shared constants and carrier types for the extended parallel port core
package ecpp_pkg;
  // register offsets from the port base
  localparam logic [10:0] OFS_DATA = 11'h000;
  localparam logic [10:0] OFS_STAT = 11'h001;
  localparam logic [10:0] OFS_CTRL = 11'h002;
  localparam logic [10:0] OFS_FIFO = 11'h400;
  localparam logic [10:0] OFS_CFGB = 11'h401;
  localparam logic [10:0] OFS_ECR  = 11'h402;
  // mode codes held in extended control bits 7..5
  localparam logic [2:0] MODE_STD  = 3'h0;
  localparam logic [2:0] MODE_BIDI = 3'h1;
  localparam logic [2:0] MODE_FIFO = 3'h2;
  localparam logic [2:0] MODE_ECP  = 3'h3;
  localparam logic [2:0] MODE_EPP  = 3'h4;
  localparam logic [2:0] MODE_TEST = 3'h6;
  localparam logic [2:0] MODE_CFG  = 3'h7;
  // field positions
  localparam int ECR_MODE_LSB = 5;
  localparam int ECR_DMA_EN   = 3;
  localparam int ECR_SVC      = 2;
  localparam int CTRL_DIR     = 5;
  localparam int CTRL_IRQ_EN  = 4;
  localparam int CTRL_SELIN   = 3;
  localparam int CTRL_INIT    = 2;
  localparam int CTRL_AUTOFD  = 1;
  localparam int CTRL_STROBE  = 0;
  localparam int RLE_CMD_BIT  = 7;
  // reset values and fixed read values
  localparam logic [5:0] CTRL_RST     = 6'h00;
  localparam logic [5:0] ECR_RST      = 6'h01;
  localparam logic [2:0] CFGB_LOW_RST = 3'h7;
  localparam logic [7:0] CFGA_VAL     = 8'h10;
  localparam logic [1:0] CTRL_HI_VAL  = 2'h3;
  localparam logic [2:0] STAT_LO_VAL  = 3'h7;
  // handshake timing
  localparam int CLK_NS      = 10;
  localparam int T_SETUP_NS  = 500;
  localparam int T_STROBE_NS = 500;
  localparam int T_HOLD_NS   = 500;
  localparam int SETUP_CYC   = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_CYC  = (T_STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC    = (T_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int FIFO_BYTES  = 16;
  // status pins from the peripheral
  typedef struct packed {
    logic busy;
    logic acknowledge_in;
    logic paper_error_in;
    logic select;
    logic fault_in;
    logic irq_line;
  } ecpp_stat_s;
  // control pins to the peripheral, at pin level
  typedef struct packed {
    logic strobe_out;
    logic auto_feed_out;
    logic init_out;
    logic select_in_out;
  } ecpp_ctrl_s;
  // fifo word: tag set for an address or run-length byte
  typedef struct packed {
    logic       tag;
    logic [7:0] data;
  } ecpp_word_s;
  // transfer engine, one-hot
  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_LOAD  = 6'b000010,
    ST_STB   = 6'b000100,
    ST_HOLD  = 6'b001000,
    ST_RPUSH = 6'b010000,
    ST_RACK  = 6'b100000
  } ecpp_state_e;
endpackage

// *** ecpp_fifo.sv ***
// small synchronous fifo with registered read data
`timescale 1ns/1ps
module ecpp_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_rst,
  input  wire logic             i_ce,
  input  wire logic             i_clear,
  input  wire logic             i_wr_valid,
  output logic                  o_wr_ready,
  input  wire logic [WIDTH-1:0] i_wr_data,
  output logic                  o_rd_valid,
  input  wire logic             i_rd_ready,
  output logic      [WIDTH-1:0] o_rd_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  // full and empty come straight from the count, so both are exact
  assign o_wr_ready = (count_reg != (AW+1)'(DEPTH));
  assign o_rd_valid = (count_reg != '0);
  assign push       = i_wr_valid && o_wr_ready;
  assign pop        = i_rd_ready && o_rd_valid;

  // storage has no reset, it is cheaper and its content is never read stale
  always_ff @(posedge i_clk_sys) begin
    if (i_ce && push) begin
      mem[wr_ptr_reg] <= i_wr_data;
    end
  end

  // pointers and count; clear drops everything held
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else if (i_ce) begin
      if (i_clear) begin
        wr_ptr_reg <= '0;
        rd_ptr_reg <= '0;
        count_reg  <= '0;
      end else begin
        if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
        if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
        count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
    end
  end

  // read word lands one cycle after the pop
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_rd_data <= '0;
    end else if (i_ce && pop) begin
      o_rd_data <= mem[rd_ptr_reg];
    end
  end
endmodule

// *** ecpp_core.sv ***
// extended capabilities parallel port: registers, shared fifo and transfer engine
`timescale 1ns/1ps
module ecpp_core #(
  parameter int FIFO_DEPTH = ecpp_pkg::FIFO_BYTES
) (
  input  wire logic               i_clk_sys,
  input  wire logic               i_rst,
  input  wire logic               i_ce,
  input  wire logic [10:0]        i_io_addr,
  input  wire logic               i_io_wr,
  input  wire logic               i_io_rd,
  input  wire logic [7:0]         i_io_wdata,
  output logic      [7:0]         o_io_rdata,
  output logic                    o_io_rvalid,
  output logic                    o_dma_req,
  input  wire logic               i_dma_wr,
  input  wire logic               i_dma_rd,
  input  wire logic               i_dma_tc,
  input  wire logic               i_epp_option,
  input  wire logic [2:0]         i_irq_select,
  input  wire ecpp_pkg::ecpp_stat_s i_stat,
  input  wire logic [7:0]         i_pd,
  output logic      [7:0]         o_pd,
  output logic                    o_pd_oe_n,
  output ecpp_pkg::ecpp_ctrl_s    o_ctrl,
  output logic                    o_ack_irq,
  output logic                    o_epp_active
);
  import ecpp_pkg::*;

  ecpp_stat_s  stat_s1_reg, stat_reg;
  logic [7:0]  pd_s1_reg, pd_reg;
  logic [7:0]  data_reg;
  logic [5:0]  ctrl_reg;
  logic [5:0]  ecr_reg;
  logic [2:0]  cfgb_low_reg;
  logic [2:0]  mode;
  logic        dir_in;
  logic        auto_fwd, auto_rev, fifo_mode;
  logic        rd_pend_reg;
  logic [10:0] rd_addr_reg;
  logic        ack_prev_reg;
  ecpp_state_e state_reg;
  logic [7:0]  timer_reg;
  logic [7:0]  byte_reg;
  logic        tag_reg;
  logic [6:0]  rep_reg, rle_reg;
  logic        host_fifo_wr, host_fifo_rd, host_push, host_pop;
  logic        eng_pop, eng_push;
  logic        f_wr_ready, f_rd_valid;
  ecpp_word_s  f_wr_word, f_rd_word;
  logic [7:0]  rd_mux;

  assign mode   = ecr_reg[5:3];
  // modes 000 and 010 always drive, every other mode obeys the bit
  assign dir_in = ctrl_reg[CTRL_DIR] && (mode != MODE_STD) && (mode != MODE_FIFO);
  // reserved 101 falls outside both automatic cases, so it acts like bidirectional
  assign auto_fwd  = (mode == MODE_FIFO) || (mode == MODE_ECP && !dir_in);
  assign auto_rev  = (mode == MODE_ECP) && dir_in;
  assign fifo_mode = (mode == MODE_FIFO) || (mode == MODE_ECP) || (mode == MODE_TEST);

  // two-flop synchronisers on every pin input
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      stat_s1_reg <= '0;
      stat_reg    <= '0;
      pd_s1_reg   <= '0;
      pd_reg      <= '0;
    end else if (i_ce) begin
      stat_s1_reg <= i_stat;
      stat_reg    <= stat_s1_reg;
      pd_s1_reg   <= i_pd;
      pd_reg      <= pd_s1_reg;
    end
  end

  // host fifo writes at 0x400 in fifo-bearing modes except reverse ecp, reads pop only in reverse ecp and test; dma pulses alike
  assign host_fifo_wr = (i_io_wr && i_io_addr == OFS_FIFO && fifo_mode && !auto_rev)
                      || (i_dma_wr && fifo_mode && !auto_rev);
  assign host_push    = host_fifo_wr
                      || (i_io_wr && i_io_addr == OFS_DATA && mode == MODE_ECP && !dir_in);
  assign host_fifo_rd = (i_io_rd && i_io_addr == OFS_FIFO) || i_dma_rd;
  assign host_pop     = host_fifo_rd && (auto_rev || mode == MODE_TEST);

  // one shared store for every fifo view; the engine owns it in automatic modes
  assign f_wr_word.tag  = eng_push ? 1'b0 : (i_io_addr == OFS_DATA && !i_dma_wr);
  assign f_wr_word.data = eng_push ? byte_reg : i_io_wdata;
  ecpp_fifo #(
    .WIDTH ($bits(ecpp_word_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk_sys  (i_clk_sys),
    .i_rst      (i_rst),
    .i_ce       (i_ce),
    .i_clear    (mode == MODE_STD),
    .i_wr_valid (eng_push || host_push),
    .o_wr_ready (f_wr_ready),
    .i_wr_data  (f_wr_word),
    .o_rd_valid (f_rd_valid),
    .i_rd_ready (eng_pop || host_pop),
    .o_rd_data  (f_rd_word)
  );

  // data latch takes writes to offset 0 outside ecp mode
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      data_reg <= '0;
    end else if (i_ce && i_io_wr && i_io_addr == OFS_DATA && mode != MODE_ECP) begin
      data_reg <= i_io_wdata;
    end
  end

  // control register keeps only bits 5..0; the top two are constants
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ctrl_reg <= CTRL_RST;
    end else if (i_ce && i_io_wr && i_io_addr == OFS_CTRL) begin
      ctrl_reg <= i_io_wdata[5:0];
    end
  end

  // extended control: mode, fault irq enable, dma enable, service bit
  // terminal count with dma enabled sets the service bit and wins over a write that clears it
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ecr_reg <= ECR_RST;
    end else if (i_ce) begin
      if (i_io_wr && i_io_addr == OFS_ECR) begin
        ecr_reg <= i_io_wdata[7:2];
      end
      if (i_dma_tc && ecr_reg[ECR_DMA_EN-2]) begin
        ecr_reg[ECR_SVC-2] <= 1'b1;
      end
    end
  end

  // configuration b low bits are plain storage
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cfgb_low_reg <= CFGB_LOW_RST;
    end else if (i_ce && i_io_wr && i_io_addr == OFS_CFGB && mode == MODE_CFG) begin
      cfgb_low_reg <= i_io_wdata[2:0];
    end
  end

  // read decode; fifo data is valid one cycle after the pop, hence the delay
  always_comb begin
    rd_mux = 8'hff;
    case (rd_addr_reg)
      OFS_DATA: rd_mux = (mode == MODE_ECP) ? 8'hff : pd_reg;
      OFS_STAT: rd_mux = {~stat_reg.busy, stat_reg.acknowledge_in, stat_reg.paper_error_in,
                          stat_reg.select, stat_reg.fault_in, STAT_LO_VAL};
      OFS_CTRL: rd_mux = {CTRL_HI_VAL, ctrl_reg};
      OFS_FIFO: rd_mux = (mode == MODE_CFG) ? CFGA_VAL : f_rd_word.data;
      OFS_CFGB: rd_mux = (mode == MODE_CFG) ?
                         {1'b0, stat_reg.irq_line, i_irq_select, cfgb_low_reg} : 8'hff;
      OFS_ECR:  rd_mux = {ecr_reg, ~f_wr_ready, ~f_rd_valid};
      default:  rd_mux = 8'hff;
    endcase
  end

  // read answer two cycles after the strobe
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rd_pend_reg <= 1'b0;
      rd_addr_reg <= '0;
      o_io_rdata  <= '0;
      o_io_rvalid <= 1'b0;
    end else if (i_ce) begin
      rd_pend_reg <= i_io_rd || i_dma_rd;
      rd_addr_reg <= i_dma_rd ? OFS_FIFO : i_io_addr;
      o_io_rvalid <= rd_pend_reg;
      if (rd_pend_reg) o_io_rdata <= rd_mux;
    end
  end

  // dma request: fill while room forward, drain while data in reverse
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_dma_req <= 1'b0;
    end else if (i_ce) begin
      o_dma_req <= ecr_reg[ECR_DMA_EN-2] && !ecr_reg[ECR_SVC-2] && fifo_mode
                   && (dir_in ? f_rd_valid : f_wr_ready);
    end
  end

  // acknowledge rising edge gives a one-cycle interrupt request
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ack_prev_reg <= 1'b0;
      o_ack_irq    <= 1'b0;
    end else if (i_ce) begin
      ack_prev_reg <= stat_reg.acknowledge_in;
      o_ack_irq    <= ctrl_reg[CTRL_IRQ_EN] && stat_reg.acknowledge_in && !ack_prev_reg;
    end
  end

  // epp cycles themselves live elsewhere; this only grants them
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_epp_active <= 1'b0;
    end else if (i_ce) begin
      o_epp_active <= (mode == MODE_EPP) && i_epp_option;
    end
  end

  assign eng_pop  = (state_reg == ST_IDLE) && auto_fwd && f_rd_valid && !stat_reg.busy;
  assign eng_push = (state_reg == ST_RPUSH) && f_wr_ready;

  // transfer engine; leaving the automatic modes drops it back to idle
  // a byte already popped is lost on such a switch, software must drain first
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= ST_IDLE;
      timer_reg <= '0;
      byte_reg  <= '0;
      tag_reg   <= 1'b0;
      rep_reg   <= '0;
      rle_reg   <= '0;
    end else if (i_ce) begin
      if (timer_reg != '0) timer_reg <= timer_reg - 1'b1;
      case (state_reg)
        ST_IDLE: begin
          if (eng_pop) begin
            state_reg <= ST_LOAD;
          end else if (auto_rev && !stat_reg.acknowledge_in) begin
            byte_reg <= pd_reg;
            rep_reg  <= rle_reg;
            rle_reg  <= '0;
            // command phase with bit 7 clear carries a repeat count
            if (!stat_reg.busy) begin
              if (!pd_reg[RLE_CMD_BIT]) rle_reg <= pd_reg[6:0];
              state_reg <= ST_RACK;
            end else begin
              state_reg <= ST_RPUSH;
            end
          end
        end
        ST_LOAD: begin
          byte_reg  <= f_rd_word.data;
          tag_reg   <= f_rd_word.tag;
          timer_reg <= 8'(SETUP_CYC);
          state_reg <= ST_STB;
        end
        ST_STB: begin
          // strobe starts after setup; ecp also waits for the peripheral ack
          if (timer_reg == '0 && (mode == MODE_FIFO || stat_reg.busy)) begin
            timer_reg <= 8'(HOLD_CYC);
            state_reg <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (timer_reg == '0 && !stat_reg.busy) state_reg <= ST_IDLE;
        end
        ST_RPUSH: begin
          // back-pressure: stays here while the fifo is full
          if (f_wr_ready) begin
            if (rep_reg == '0) state_reg <= ST_RACK;
            else rep_reg <= rep_reg - 1'b1;
          end
        end
        ST_RACK: begin
          if (stat_reg.acknowledge_in) state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
      if (!auto_fwd && !auto_rev) state_reg <= ST_IDLE;
    end
  end

  // pins: in the automatic forward modes strobe is low in the cycle after each one the engine spends in the strobe state with setup run out
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_ctrl    <= '1;
      o_pd      <= '0;
      o_pd_oe_n <= 1'b0;
    end else if (i_ce) begin
      o_ctrl.init_out      <= ctrl_reg[CTRL_INIT];
      o_ctrl.select_in_out <= ~ctrl_reg[CTRL_SELIN];
      if (auto_fwd) begin
        o_ctrl.strobe_out    <= !(state_reg == ST_STB && timer_reg == '0);
        o_ctrl.auto_feed_out <= !(mode == MODE_ECP && tag_reg);
      end else if (auto_rev) begin
        o_ctrl.strobe_out    <= 1'b1;
        o_ctrl.auto_feed_out <= (state_reg == ST_RACK || state_reg == ST_RPUSH);
      end else begin
        o_ctrl.strobe_out    <= ~ctrl_reg[CTRL_STROBE];
        o_ctrl.auto_feed_out <= ~ctrl_reg[CTRL_AUTOFD];
      end
      o_pd      <= auto_fwd ? byte_reg : data_reg;
      o_pd_oe_n <= dir_in;
    end
  end

  property p_stat_low;
    @(posedge i_clk_sys) disable iff (i_rst || !i_ce)
      (i_io_rd && i_io_addr == OFS_STAT) |-> ##2 (o_io_rvalid && o_io_rdata[2:0] == 3'h7);
  endproperty
  a_stat_low: assert property (p_stat_low) else $error("status low bits not one");

  property p_ctrl_hi;
    @(posedge i_clk_sys) disable iff (i_rst || !i_ce)
      (i_io_rd && i_io_addr == OFS_CTRL) |-> ##2 (o_io_rdata[7:6] == 2'h3);
  endproperty
  a_ctrl_hi: assert property (p_ctrl_hi) else $error("control top bits not one");

  property p_cfga;
    @(posedge i_clk_sys) disable iff (i_rst || !i_ce)
      (i_io_rd && i_io_addr == OFS_FIFO && mode == MODE_CFG && !i_io_wr)
        |=> (mode != MODE_CFG) or ##1 (o_io_rdata == 8'h10);
  endproperty
  a_cfga: assert property (p_cfga) else $error("configuration a not 10h");

  property p_cfgb7;
    @(posedge i_clk_sys) disable iff (i_rst || !i_ce)
      (i_io_rd && i_io_addr == OFS_CFGB && mode == MODE_CFG && !i_io_wr)
        |-> ##2 (!o_io_rdata[7] && o_io_rdata[5:3] == $past(i_irq_select, 1));
  endproperty
  a_cfgb7: assert property (p_cfgb7) else $error("configuration b fields wrong");

  property p_std_clear;
    @(posedge i_clk_sys) disable iff (i_rst || !i_ce)
      (mode == MODE_STD) |=> !f_rd_valid;
  endproperty
  a_std_clear: assert property (p_std_clear) else $error("fifo not emptied in mode 000");

  property p_dir_fixed;
    @(posedge i_clk_sys) disable iff (i_rst || !i_ce)
      (mode == MODE_STD || mode == MODE_FIFO) |=> !o_pd_oe_n;
  endproperty
  a_dir_fixed: assert property (p_dir_fixed) else $error("data lines not driven");

  property p_ack_irq;
    @(posedge i_clk_sys) disable iff (i_rst || !i_ce)
      (ctrl_reg[CTRL_IRQ_EN] && $rose(stat_reg.acknowledge_in)) |=> o_ack_irq;
  endproperty
  a_ack_irq: assert property (p_ack_irq) else $error("ack edge lost");

  property p_test_quiet;
    @(posedge i_clk_sys) disable iff (i_rst || !i_ce)
      (mode == MODE_TEST) [*2] |=> (state_reg == ST_IDLE && o_ctrl.strobe_out == !$past(ctrl_reg[0], 1));
  endproperty
  a_test_quiet: assert property (p_test_quiet) else $error("handshake in test mode");

  property p_empty_flag;
    @(posedge i_clk_sys) disable iff (i_rst || !i_ce)
      (i_io_rd && i_io_addr == OFS_ECR && mode == MODE_STD && !i_io_wr) |-> ##2 o_io_rdata[0];
  endproperty
  a_empty_flag: assert property (p_empty_flag) else $error("empty flag clear in mode 000");
endmodule

// *** ecpp_printer_model.sv ***
// printer side model: answers each strobe with busy and captures the byte
`timescale 1ns/1ps
module ecpp_printer_model (
  input  wire logic       i_clk_sys,
  input  wire logic       i_strobe_n,
  input  wire logic       i_afd_n,
  input  wire logic [7:0] i_pd,
  output logic            o_busy,
  output logic [7:0]      o_byte,
  output logic            o_tag,
  output int              o_count
);
  logic stb_q = 1'b1;
  // busy follows strobe, so the engine always sees a full handshake
  always @(posedge i_clk_sys) begin
    stb_q <= i_strobe_n;
    o_busy <= !i_strobe_n;
    if (stb_q && !i_strobe_n) begin
      o_byte <= i_pd;
      o_tag <= !i_afd_n;
      o_count <= o_count + 1;
    end
  end
  initial begin
    o_busy = 1'b0;
    o_count = 0;
  end
endmodule

// *** tb_top.sv ***
// self-checking bench for the parallel port core
`timescale 1ns/1ps
module tb_top;
  import ecpp_pkg::*;
  logic        clk;
  logic        rst;
  logic [10:0] addr;
  logic        wr_s;
  logic        rd_s;
  logic        dwr;
  logic        drd;
  logic        dtc;
  logic        eppo;
  logic [2:0]  irqs;
  logic [4:0]  pins;
  logic [7:0]  wdat;
  logic [7:0]  d;
  logic [7:0]  o_rd;
  logic [7:0]  o_pd;
  logic [7:0]  pd_w;
  logic [7:0]  pbyte;
  logic        o_rv;
  logic        oe_n;
  logic        dreq;
  logic        irqp;
  logic        eppa;
  logic        busy;
  logic        ptag;
  int          pcnt;
  int          err_total;
  int          tests_run;
  ecpp_ctrl_s  ctrl;
  ecpp_stat_s  st;
  // a released bus shows the inverse of the last driven byte
  assign pd_w = oe_n ? ~o_pd : o_pd;
  assign st = {busy, pins};
  ecpp_core dut_u (.i_clk_sys(clk), .i_rst(rst), .i_ce(1'b1), .i_io_addr(addr),
    .i_io_wr(wr_s), .i_io_rd(rd_s), .i_io_wdata(wdat), .o_io_rdata(o_rd),
    .o_io_rvalid(o_rv), .o_dma_req(dreq), .i_dma_wr(dwr), .i_dma_rd(drd),
    .i_dma_tc(dtc), .i_epp_option(eppo), .i_irq_select(irqs), .i_stat(st),
    .i_pd(pd_w), .o_pd(o_pd), .o_pd_oe_n(oe_n), .o_ctrl(ctrl),
    .o_ack_irq(irqp), .o_epp_active(eppa));
  ecpp_printer_model prn_u (.i_clk_sys(clk), .i_strobe_n(ctrl.strobe_out),
    .i_afd_n(ctrl.auto_feed_out), .i_pd(o_pd), .o_busy(busy), .o_byte(pbyte),
    .o_tag(ptag), .o_count(pcnt));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // one host write, strobe dropped a full cycle before the next request
  task automatic wr(input logic [10:0] a, input logic [7:0] v);
    addr = a;
    wdat = v;
    wr_s = 1'b1;
    @(negedge clk);
    wr_s = 1'b0;
    @(negedge clk);
  endtask
  // one host read; the answer is caught in the cycle its valid stands
  task automatic rd(input logic [10:0] a, output logic [7:0] v);
    addr = a;
    rd_s = 1'b1;
    v = 8'hxx;
    @(negedge clk);
    rd_s = 1'b0;
    repeat (4) begin
      @(posedge clk);
      #1;
      if (o_rv === 1'b1) v = o_rd;
    end
    @(negedge clk);
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  // bounded wait for the printer to take n bytes in total
  task automatic wait_bytes(input int n);
    repeat (3000) if (pcnt < n) @(negedge clk);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // the whole sequence needs well under 5k cycles
  initial begin
    #500000;
    err_total++;
    end_of_test();
  end
  initial begin
    {rst, wr_s, rd_s, dwr, eppo, drd, dtc} = 7'h40;
    {addr, wdat, irqs} = 22'h0;
    pins = 5'h1a;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    rd(OFS_ECR, d); chk("ecr", 8'h05, d);
    rd(OFS_STAT, d); chk("status", 8'hef, d);
    pins = 5'h16;
    repeat (4) @(negedge clk);
    rd(OFS_STAT, d); chk("status", 8'hdf, d);
    wr(OFS_CTRL, 8'h1e);
    rd(OFS_CTRL, d); chk("control", 8'hde, d);
    chk("pins", 8'h0a, {4'h0, ctrl});
    pins[4] = 1'b0;
    repeat (4) @(negedge clk);
    pins[4] = 1'b1;
    // the pulse stands one cycle, so look at it between edges, never on one
    repeat (8) if (irqp !== 1'b1) @(negedge clk);
    chk("ack irq", 8'h01, {7'h0, irqp});
    $display("test status and control finished");
    @(negedge clk);
    wr(OFS_DATA, 8'ha5);
    // registered pin drive plus two synchroniser stages before the read sees it
    repeat (3) @(negedge clk);
    rd(OFS_DATA, d); chk("data", 8'ha5, d);
    wr(OFS_CTRL, 8'h3e);
    chk("drive std", 8'h00, {7'h0, oe_n});
    wr(OFS_ECR, 8'h20);
    repeat (3) @(negedge clk);
    rd(OFS_DATA, d); chk("data in", 8'h5a, d);
    chk("drive bidi", 8'h01, {7'h0, oe_n});
    wr(OFS_CTRL, 8'h00);
    wr(OFS_ECR, 8'h80);
    chk("epp off", 8'h00, {7'h0, eppa});
    eppo = 1'b1;
    repeat (3) @(negedge clk);
    chk("epp on", 8'h01, {7'h0, eppa});
    $display("test data port and modes finished");
    wr(OFS_ECR, 8'he0);
    rd(OFS_FIFO, d); chk("cfg a", CFGA_VAL, d);
    for (int k = 0; k < 8; k++) begin
      irqs = k[2:0];
      pins[0] = k[0];
      repeat (4) @(negedge clk);
      rd(OFS_CFGB, d); chk("cfg b", {1'b0, k[0], k[2:0], 3'h7}, d);
    end
    $display("test configuration finished");
    wr(OFS_ECR, 8'hc0);
    for (int i = 0; i < 17; i++) wr(OFS_FIFO, 8'h10 + i[7:0]);
    rd(OFS_ECR, d); chk("full", 8'hc2, d);
    chk("no handshake", 8'h00, pcnt[7:0]);
    for (int i = 0; i < 16; i++) begin
      rd(OFS_FIFO, d); chk("fifo", 8'h10 + i[7:0], d);
    end
    rd(OFS_ECR, d); chk("empty", 8'hc1, d);
    wr(OFS_FIFO, 8'h01);
    wr(OFS_ECR, 8'h00);
    wr(OFS_ECR, 8'hc8);
    rd(OFS_ECR, d); chk("flushed", 8'hc9, d);
    chk("dma req", 8'h01, {7'h0, dreq});
    wdat = 8'h77;
    dwr = 1'b1;
    @(negedge clk);
    dwr = 1'b0;
    rd(OFS_FIFO, d); chk("dma byte", 8'h77, d);
    // dma write then dma read; the read answer lands on the host read data
    wdat = 8'h66;
    dwr = 1'b1;
    @(negedge clk);
    dwr = 1'b0;
    drd = 1'b1;
    @(negedge clk);
    drd = 1'b0;
    repeat (2) @(negedge clk);
    chk("dma read", 8'h66, o_rd);
    // terminal count raises the service bit, which withdraws the request
    dtc = 1'b1;
    @(negedge clk);
    dtc = 1'b0;
    repeat (2) @(negedge clk);
    chk("dma stop", 8'h00, {7'h0, dreq});
    $display("test fifo finished");
    wr(OFS_ECR, 8'h40);
    wr(OFS_FIFO, 8'h81);
    wr(OFS_FIFO, 8'h82);
    wait_bytes(2);
    chk("sent", 8'h82, pbyte);
    chk("sent count", 8'h02, pcnt[7:0]);
    wr(OFS_ECR, 8'h60);
    wr(OFS_DATA, 8'h33);
    wait_bytes(3);
    chk("tagged", 8'hb3, {ptag, pbyte[6:0]});
    wr(OFS_FIFO, 8'h44);
    wait_bytes(4);
    chk("ecp data", 8'h44, {ptag, pbyte[6:0]});
    $display("test transmit finished");
    end_of_test();
  end
endmodule
